// ### verilog/djk_top.sv
`timescale 1ns/1ps
// ==========================================================
// dual falling-edge J-K storage with async set and reset
module djk_top #(
  parameter int ELEMS = djk_pkg::DJK_ELEMS
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [ELEMS-1:0] elem_clk,
  input  wire logic [ELEMS-1:0] steer_set,
  input  wire logic [ELEMS-1:0] steer_reset,
  input  wire logic [ELEMS-1:0] async_set_n,
  input  wire logic [ELEMS-1:0] async_reset_n,
  output logic      [ELEMS-1:0] q,
  output logic      [ELEMS-1:0] q_n
);
  import djk_pkg::*;

  typedef struct packed {
    logic [ELEMS-1:0] clk_prev;
    logic [ELEMS-1:0] stored;
    logic [ELEMS-1:0] q;
    logic [ELEMS-1:0] qn;
  } djk_top_state_t;

  djk_top_state_t st_ff;
  djk_top_state_t nxt_st;

  // synchronised pin copies
  logic [ELEMS-1:0] clk_s;
  logic [ELEMS-1:0] set_s;
  logic [ELEMS-1:0] rst_s;
  logic [ELEMS-1:0] aset_s;
  logic [ELEMS-1:0] arst_s;
  logic [ELEMS-1:0] fall;
  logic [ELEMS-1:0] inactive;

  // ==========================================================
  // input synchronisers, one per element
  genvar g;
  generate
    for (g = 0; g < ELEMS; g++)
    begin : g_sync
      logic [DJK_SYNC_BITS-1:0] pins;
      logic [DJK_SYNC_BITS-1:0] synced;

      assign pins = {elem_clk[g], steer_set[g], steer_reset[g],
                     async_set_n[g], async_reset_n[g]};

      djk_sync #(
        .WIDTH   (DJK_SYNC_BITS),
        .RST_VAL (DJK_SYNC_RST)
      ) u_sync (
        .clock    (clock),
        .rstn     (rstn),
        .pin_in   (pins),
        .sync_out (synced)
      );

      // each element owns its own pins
      assign clk_s[g]  = synced[DJK_BIT_CLK];
      assign set_s[g]  = synced[DJK_BIT_SET];
      assign rst_s[g]  = synced[DJK_BIT_RST];
      assign aset_s[g] = synced[DJK_BIT_ASET];
      assign arst_s[g] = synced[DJK_BIT_ARST];
    end
  endgenerate

  // falling edge of each element clock
  assign fall     = st_ff.clk_prev & ~clk_s;
  assign inactive = aset_s & arst_s;

  // ==========================================================
  // next-state logic for all elements
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.clk_prev = clk_s;
    for (int i = 0; i < ELEMS; i++)
    begin
      if (!aset_s[i] && !arst_s[i])
      begin
        // both forced high, stored level left alone
        nxt_st.q[i]  = 1'h1;
        nxt_st.qn[i] = 1'h1;
      end
      else
      begin
        if (!aset_s[i])
        begin
          nxt_st.stored[i] = 1'h1;
        end
        else if (!arst_s[i])
        begin
          nxt_st.stored[i] = 1'h0;
        end
        else if (fall[i])
        begin
          // steering acts only on the falling edge
          case ({set_s[i], rst_s[i]})
            DJK_JK_HOLD:   nxt_st.stored[i] = st_ff.stored[i];
            DJK_JK_LOAD0:  nxt_st.stored[i] = 1'h0;
            DJK_JK_LOAD1:  nxt_st.stored[i] = 1'h1;
            default:       nxt_st.stored[i] = ~st_ff.stored[i];
          endcase
        end
        // complementary outputs follow the stored level
        nxt_st.q[i]  = nxt_st.stored[i];
        nxt_st.qn[i] = ~nxt_st.stored[i];
      end
    end
  end

  // state register, synchronous reset; reset clears stored level and q, sets q_n
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_ff.clk_prev <= {ELEMS{DJK_PREV_RST}};
      st_ff.stored   <= {ELEMS{DJK_STORE_RST}};
      st_ff.q        <= {ELEMS{DJK_STORE_RST}};
      st_ff.qn       <= {ELEMS{~DJK_STORE_RST}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign q   = st_ff.q;
  assign q_n = st_ff.qn;

  // ==========================================================
  // assertions per element
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  generate
    for (g = 0; g < ELEMS; g++)
    begin : g_chk
      logic act;
      assign act = inactive[g];

      a_async_set: assert property (
        (!aset_s[g] && arst_s[g]) |=> (q[g] && !q_n[g]))
        else $error("async set did not force true high");

      a_async_reset: assert property (
        (aset_s[g] && !arst_s[g]) |=> (!q[g] && q_n[g]))
        else $error("async reset did not force true low");

      a_both_low: assert property (
        (!aset_s[g] && !arst_s[g]) |=> (q[g] && q_n[g]))
        else $error("both async low did not drive both high");

      a_outputs_compl: assert property (
        act |=> (q_n[g] == ~q[g]) && (q[g] == st_ff.stored[g]))
        else $error("outputs not complementary to stored level");

      a_steady_clock: assert property (
        (act && !fall[g]) |=> $stable(st_ff.stored[g]))
        else $error("stored level changed without falling edge");

      a_edge_only: assert property (
        (!$stable(st_ff.stored[g])) |->
          $past(fall[g] || !aset_s[g] || !arst_s[g]))
        else $error("stored level changed without a cause");

      a_jk_hold: assert property (
        (act && fall[g] && !set_s[g] && !rst_s[g])
          |=> $stable(st_ff.stored[g]))
        else $error("hold steering changed stored level");

      a_jk_load1: assert property (
        (act && fall[g] && set_s[g] && !rst_s[g])
          |=> (q[g] && !q_n[g]))
        else $error("set steering did not load one");

      a_jk_load0: assert property (
        (act && fall[g] && !set_s[g] && rst_s[g])
          |=> (!q[g] && q_n[g]))
        else $error("reset steering did not load zero");

      a_jk_toggle: assert property (
        (act && fall[g] && set_s[g] && rst_s[g])
          |=> (st_ff.stored[g] == ~$past(st_ff.stored[g])))
        else $error("toggle steering did not invert");

      a_pin_latency: assert property (
        (elem_clk[g] ##1 !elem_clk[g] ##1 1'h1 ##1 act)
          |-> fall[g])
        else $error("pin falling edge not seen after two stages");

      c_toggle: cover property (
        act && fall[g] && set_s[g] && rst_s[g]);
      c_load: cover property (act && fall[g] && (set_s[g] ^ rst_s[g]));
      c_both_low: cover property (!aset_s[g] && !arst_s[g]);
      c_async_set: cover property (!aset_s[g] && arst_s[g]);
    end
  endgenerate

endmodule

// ### verilog/djk_pkg.sv

// ==========================================================
// shared constants
package djk_pkg;

  localparam int          DJK_ELEMS      = 2;   // element count
  localparam int          DJK_SYNC_BITS  = 5;   // pin bits per element
  localparam logic        DJK_STORE_RST  = 1'h0;
  localparam logic        DJK_PREV_RST   = 1'h0; // no false edge at release
  // synchroniser reset value: clock, set, reset, set_n, reset_n
  localparam logic [4:0]  DJK_SYNC_RST   = 5'h03;
  // bit positions of each pin inside the synchroniser word
  localparam int          DJK_BIT_CLK    = 4;
  localparam int          DJK_BIT_SET    = 3;
  localparam int          DJK_BIT_RST    = 2;
  localparam int          DJK_BIT_ASET   = 1;
  localparam int          DJK_BIT_ARST   = 0;
  // steering codes {set_steer, reset_steer}
  localparam logic [1:0]  DJK_JK_HOLD    = 2'h0;
  localparam logic [1:0]  DJK_JK_LOAD0   = 2'h1;
  localparam logic [1:0]  DJK_JK_LOAD1   = 2'h2;
  localparam logic [1:0]  DJK_JK_TOGGLE  = 2'h3;

endpackage

// ### verilog/djk_sync.sv
`timescale 1ns/1ps
// ==========================================================
// two-stage synchroniser for pin inputs
module djk_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  import djk_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } djk_sync_state_t;

  djk_sync_state_t st_ff;
  djk_sync_state_t nxt_st;

  // shift pins through two stages
  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.first  = pin_in;
    nxt_st.second = st_ff.first;
  end

  // state register, synchronous reset
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_ff <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.second;

endmodule

// ### bench/djk_far.sv
`timescale 1ns/1ps
// ====================
// far-side logic: launches wanted pin levels after each rising edge
module djk_far (
  input  wire logic       clock,
  input  wire logic [9:0] want,
  output logic      [9:0] pins
);
  // same small delay after every rising edge; idle levels come from want
  always @(posedge clock)
    pins <= #1 want;
endmodule

// ### bench/djk_top_tb.sv
`timescale 1ns/1ps
// ====================
// bench for the dual j-k storage elements
module djk_top_tb;
  import djk_pkg::*;
  logic        clock = 1'h0;
  logic        rstn = 1'h0;
  logic        due = 1'h0;
  logic [9:0]  want = 10'h00F;
  logic [9:0]  pins;
  logic [1:0]  q;
  logic [1:0]  q_n;
  logic [1:0]  st;
  logic [1:0]  m;
  logic [3:0]  exp_q[$];
  logic [31:0] seed = 32'h2;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  djk_far far (.clock(clock), .want(want), .pins(pins));
  djk_top uut (.clock(clock), .rstn(rstn), .elem_clk(pins[9:8]),
    .steer_set(pins[7:6]), .steer_reset(pins[5:4]),
    .async_set_n(pins[3:2]), .async_reset_n(pins[1:0]),
    .q(q), .q_n(q_n));

  // 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string nm, input logic [3:0] seen,
                       input logic [3:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // queue the expected outputs, flag the watcher
  task automatic note(input logic [3:0] e);
    exp_q.push_back(e);
    due = 1'h1;
    step(1);
    due = 1'h0;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watcher: compare outputs with the oldest note
  always @(posedge clock)
  begin
    if (due)
      check("q_qn", {q, q_n}, exp_q.pop_front());
  end

  // cycle ceiling against hangs
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      fail_count++;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    step(3);
    rstn = 1'h1;
    want[3:0] = 4'h3;
    step(6);
    note(4'hC);
    want[3:0] = 4'hC;
    step(6);
    note(4'h3);
    want[3:0] = 4'h0;
    step(6);
    note(4'hF);
    want[3:0] = 4'h9;
    step(6);
    note(4'h6);
    want[3:0] = 4'hF;
    st = 2'h1;
    step(6);
    note(4'h6);
    repeat (40)
    begin
      seed = xs(seed);
      want[7:4] = seed[3:0];
      m = seed[5:4];
      want[9:8] = 2'h3;
      step(4);
      want[9:8] = ~m;
      step(6);
      for (int i = 0; i < 2; i++)
      begin
        if (m[i])
        begin
          case ({want[6+i], want[4+i]})
            DJK_JK_LOAD0:  st[i] = 1'h0;
            DJK_JK_LOAD1:  st[i] = 1'h1;
            DJK_JK_TOGGLE: st[i] = ~st[i];
            default:       st[i] = st[i];
          endcase
        end
      end
      note({st, ~st});
      seed = xs(seed);
      want[7:4] = seed[3:0];
      step(6);
      note({st, ~st});
    end
    close_out();
  end
endmodule
